// *** core/sea_regs.svh ***
// register selects, field layouts and preset values of the status block
`ifndef SEA_REGS_SVH
`define SEA_REGS_SVH

// register select codes on the command port
`define SEA_SEL_ACT_COND   4'h0
`define SEA_SEL_ACT_EVENT  4'h1
`define SEA_SEL_ACT_ENABLE 4'h2
`define SEA_SEL_ACT_DOWN   4'h3
`define SEA_SEL_ACT_UP     4'h4
`define SEA_SEL_FLT_COND   4'h8
`define SEA_SEL_FLT_EVENT  4'h9
`define SEA_SEL_FLT_ENABLE 4'ha
`define SEA_SEL_FLT_DOWN   4'hb
`define SEA_SEL_FLT_UP     4'hc

// activity group bit positions
`define SEA_ACT_CAL_BIT    0
`define SEA_ACT_WAIT_BIT   5
`define SEA_ACT_VREG_BIT   8
`define SEA_ACT_IREG_BIT   10
`define SEA_ACT_USED       16'h0521

// fault group bit positions
`define SEA_FLT_OV_BIT     0
`define SEA_FLT_OC_BIT     1
`define SEA_FLT_HEAT_BIT   4
`define SEA_FLT_INH_BIT    9
`define SEA_FLT_UNREG_BIT  10
`define SEA_FLT_USED       16'h0613

// preset and stored-value limits
`define SEA_ACT_UP_PRESET  16'h0521
`define SEA_FLT_UP_PRESET  16'h0613
`define SEA_WRITE_MASK     16'h7fff
`define SEA_CLEAR_VALUE    16'h0000

// status byte summary positions
`define SEA_SB_ACT_BIT     7
`define SEA_SB_FLT_BIT     3

`endif

// *** core/sea_pkg.sv ***
// types shared by the status event aggregator
package sea_pkg;

    typedef enum logic [1:0] {
        SEA_OP_READ   = 2'b00,
        SEA_OP_WRITE  = 2'b01,
        SEA_OP_PRESET = 2'b10,
        SEA_OP_NONE   = 2'b11
    } sea_op_e;

    typedef logic [15:0] sea_word_t;

    // new events from filtered level terms against their previous values
    function automatic sea_word_t sea_edge_hits(
        input sea_word_t up_term,
        input sea_word_t up_term_prev,
        input sea_word_t down_term,
        input sea_word_t down_term_prev,
        input sea_word_t used
    );
        sea_edge_hits = ((up_term & ~up_term_prev)
                       | (down_term & ~down_term_prev)) & used;
    endfunction : sea_edge_hits

endpackage : sea_pkg

// *** core/sea_sync.sv ***
// two-flop synchroniser for the live status pins
`timescale 1ns/100ps
module sea_sync #(
    parameter int W = 9
) (
    // clock and reset
    input  wire logic         ref_clk_i,
    input  wire logic         rst_b_i,
    // pins and synchronised levels
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] stage1;
    logic [W-1:0] next_stage1;
    logic [W-1:0] next_sync;

    always_comb begin
        next_stage1 = async_i;
        next_sync   = stage1;
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            stage1 <= '0;
            sync_o <= '0;
        end else begin
            stage1 <= next_stage1;
            sync_o <= next_sync;
        end
    end
endmodule : sea_sync

// *** core/sea_group.sv ***
// one status group: condition, filters, latched events, enable, summary
`timescale 1ns/100ps
`include "sea_regs.svh"
module sea_group import sea_pkg::*; #(
    parameter sea_word_t USED      = 16'h0000,
    parameter sea_word_t UP_PRESET = 16'h0000
) (
    // clock and reset
    input  wire logic      ref_clk_i,
    input  wire logic      rst_b_i,
    // live status
    input  wire sea_word_t cond_i,
    // register access
    input  wire sea_word_t wdata_i,
    input  wire logic      wr_enable_i,
    input  wire logic      wr_up_i,
    input  wire logic      wr_down_i,
    input  wire logic      preset_i,
    input  wire logic      event_rd_i,
    // register views
    output sea_word_t      cond_o,
    output sea_word_t      event_o,
    output sea_word_t      enable_o,
    output sea_word_t      up_o,
    output sea_word_t      down_o,
    output logic           summary_o
);
    sea_word_t up_term_q;
    sea_word_t down_term_q;
    sea_word_t next_up_term;
    sea_word_t next_down_term;
    sea_word_t hits;
    sea_word_t next_event;
    sea_word_t next_enable;
    sea_word_t next_up;
    sea_word_t next_down;
    logic      next_summary;

    assign cond_o = cond_i & USED;

    always_comb begin
        // filters take part in the terms, so rewriting one can raise events
        next_up_term   = cond_o & up_o;
        next_down_term = ~cond_o & down_o;
        hits = sea_edge_hits(next_up_term, up_term_q, next_down_term,
                             down_term_q, USED);
        // a hit in the read cycle survives the clear
        next_event = (event_rd_i ? `SEA_CLEAR_VALUE : event_o) | hits;
        next_enable = enable_o;
        next_up     = up_o;
        next_down   = down_o;
        if (preset_i) begin
            next_enable = `SEA_CLEAR_VALUE;
            next_up     = UP_PRESET;
            next_down   = `SEA_CLEAR_VALUE;
        end else begin
            if (wr_enable_i) begin
                next_enable = wdata_i & `SEA_WRITE_MASK;
            end
            if (wr_up_i) begin
                next_up = wdata_i & `SEA_WRITE_MASK;
            end
            if (wr_down_i) begin
                next_down = wdata_i & `SEA_WRITE_MASK;
            end
        end
        next_summary = |(next_event & next_enable & USED);
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            up_term_q   <= '0;
            down_term_q <= '0;
            event_o     <= '0;
            enable_o    <= '0;
            up_o        <= '0;
            down_o      <= '0;
            summary_o   <= 1'b0;
        end else begin
            up_term_q   <= next_up_term;
            down_term_q <= next_down_term;
            event_o     <= next_event;
            enable_o    <= next_enable;
            up_o        <= next_up;
            down_o      <= next_down;
            summary_o   <= next_summary;
        end
    end
endmodule : sea_group

// *** core/sea_top.sv ***
// status event aggregator: activity and fault groups behind a command port
`timescale 1ns/100ps
`include "sea_regs.svh"
module sea_top import sea_pkg::*; (
    // clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       rst_b_i,
    // activity status pins
    input  wire logic       calibrating_i,
    input  wire logic       awaiting_launch_i,
    input  wire logic       voltage_regulating_i,
    input  wire logic       current_regulating_i,
    // fault status pins
    input  wire logic       excess_voltage_fault_i,
    input  wire logic       excess_current_fault_i,
    input  wire logic       heat_fault_i,
    input  wire logic       remote_inhibit_i,
    input  wire logic       regulation_lost_i,
    // command port
    input  wire logic       cmd_valid_i,
    input  wire logic [1:0] cmd_op_i,
    input  wire logic [3:0] cmd_sel_i,
    input  wire sea_word_t  cmd_wdata_i,
    // query answer
    output logic            rsp_valid_o,
    output sea_word_t       rsp_data_o,
    // status byte summaries
    output logic            activity_summary_o,
    output logic            fault_summary_o,
    output logic [7:0]      status_summary_o
);
    logic [8:0] pins_sync;
    sea_word_t  act_cond_raw;
    sea_word_t  flt_cond_raw;
    sea_word_t  act_cond;
    sea_word_t  act_event;
    sea_word_t  act_enable;
    sea_word_t  act_up;
    sea_word_t  act_down;
    sea_word_t  flt_cond;
    sea_word_t  flt_event;
    sea_word_t  flt_enable;
    sea_word_t  flt_up;
    sea_word_t  flt_down;
    sea_op_e    op;
    logic       is_read;
    logic       is_write;
    logic       is_preset;
    logic       next_rsp_valid;
    sea_word_t  next_rsp_data;

    // command decode, used for both reads and writes
    function automatic logic sel_is(input logic [3:0] sel,
                                    input logic [3:0] code);
        sel_is = (sel == code);
    endfunction : sel_is

    // pins are asynchronous to the register clock
    sea_sync #(
        .W (9)
    ) u_sync (
        .ref_clk_i (ref_clk_i),
        .rst_b_i   (rst_b_i),
        .async_i   ({regulation_lost_i, remote_inhibit_i, heat_fault_i,
                     excess_current_fault_i, excess_voltage_fault_i,
                     current_regulating_i, voltage_regulating_i,
                     awaiting_launch_i, calibrating_i}),
        .sync_o    (pins_sync)
    );

    always_comb begin
        act_cond_raw = '0;
        act_cond_raw[`SEA_ACT_CAL_BIT]  = pins_sync[0];
        act_cond_raw[`SEA_ACT_WAIT_BIT] = pins_sync[1];
        act_cond_raw[`SEA_ACT_VREG_BIT] = pins_sync[2];
        act_cond_raw[`SEA_ACT_IREG_BIT] = pins_sync[3];
        flt_cond_raw = '0;
        flt_cond_raw[`SEA_FLT_OV_BIT]    = pins_sync[4];
        flt_cond_raw[`SEA_FLT_OC_BIT]    = pins_sync[5];
        flt_cond_raw[`SEA_FLT_HEAT_BIT]  = pins_sync[6];
        flt_cond_raw[`SEA_FLT_INH_BIT]   = pins_sync[7];
        flt_cond_raw[`SEA_FLT_UNREG_BIT] = pins_sync[8];
    end

    assign op        = sea_op_e'(cmd_op_i);
    assign is_read   = cmd_valid_i && (op == SEA_OP_READ);
    assign is_write  = cmd_valid_i && (op == SEA_OP_WRITE);
    assign is_preset = cmd_valid_i && (op == SEA_OP_PRESET);

    sea_group #(
        .USED      (`SEA_ACT_USED),
        .UP_PRESET (`SEA_ACT_UP_PRESET)
    ) u_activity (
        .ref_clk_i   (ref_clk_i),
        .rst_b_i     (rst_b_i),
        .cond_i      (act_cond_raw),
        .wdata_i     (cmd_wdata_i),
        .wr_enable_i (is_write && sel_is(cmd_sel_i, `SEA_SEL_ACT_ENABLE)),
        .wr_up_i     (is_write && sel_is(cmd_sel_i, `SEA_SEL_ACT_UP)),
        .wr_down_i   (is_write && sel_is(cmd_sel_i, `SEA_SEL_ACT_DOWN)),
        .preset_i    (is_preset),
        .event_rd_i  (is_read && sel_is(cmd_sel_i, `SEA_SEL_ACT_EVENT)),
        .cond_o      (act_cond),
        .event_o     (act_event),
        .enable_o    (act_enable),
        .up_o        (act_up),
        .down_o      (act_down),
        .summary_o   (activity_summary_o)
    );

    sea_group #(
        .USED      (`SEA_FLT_USED),
        .UP_PRESET (`SEA_FLT_UP_PRESET)
    ) u_fault (
        .ref_clk_i   (ref_clk_i),
        .rst_b_i     (rst_b_i),
        .cond_i      (flt_cond_raw),
        .wdata_i     (cmd_wdata_i),
        .wr_enable_i (is_write && sel_is(cmd_sel_i, `SEA_SEL_FLT_ENABLE)),
        .wr_up_i     (is_write && sel_is(cmd_sel_i, `SEA_SEL_FLT_UP)),
        .wr_down_i   (is_write && sel_is(cmd_sel_i, `SEA_SEL_FLT_DOWN)),
        .preset_i    (is_preset),
        .event_rd_i  (is_read && sel_is(cmd_sel_i, `SEA_SEL_FLT_EVENT)),
        .cond_o      (flt_cond),
        .event_o     (flt_event),
        .enable_o    (flt_enable),
        .up_o        (flt_up),
        .down_o      (flt_down),
        .summary_o   (fault_summary_o)
    );

    always_comb begin
        status_summary_o = 8'h00;
        status_summary_o[`SEA_SB_ACT_BIT] = activity_summary_o;
        status_summary_o[`SEA_SB_FLT_BIT] = fault_summary_o;
    end

    // answer carries the pre-clear event value
    always_comb begin
        next_rsp_valid = is_read;
        next_rsp_data  = '0;
        if (is_read) begin
            case (cmd_sel_i)
                `SEA_SEL_ACT_COND:   next_rsp_data = act_cond;
                `SEA_SEL_ACT_EVENT:  next_rsp_data = act_event;
                `SEA_SEL_ACT_ENABLE: next_rsp_data = act_enable;
                `SEA_SEL_ACT_DOWN:   next_rsp_data = act_down;
                `SEA_SEL_ACT_UP:     next_rsp_data = act_up;
                `SEA_SEL_FLT_COND:   next_rsp_data = flt_cond;
                `SEA_SEL_FLT_EVENT:  next_rsp_data = flt_event;
                `SEA_SEL_FLT_ENABLE: next_rsp_data = flt_enable;
                `SEA_SEL_FLT_DOWN:   next_rsp_data = flt_down;
                `SEA_SEL_FLT_UP:     next_rsp_data = flt_up;
                default:             next_rsp_data = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            rsp_valid_o <= 1'b0;
            rsp_data_o  <= '0;
        end else begin
            rsp_valid_o <= next_rsp_valid;
            rsp_data_o  <= next_rsp_data;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);

    property p_act_rise_latch;
        ((act_cond & ~$past(act_cond) & act_up & $past(act_up)) != 16'h0)
            |=> ((act_event & $past(act_cond & act_up)) != 16'h0);
    endproperty
    a_act_rise_latch: assert property (p_act_rise_latch)
        else $error("activity rising edge not latched");

    property p_flt_fall_latch;
        ((~flt_cond & $past(flt_cond) & flt_down & $past(flt_down)) != 16'h0)
            |=> ((flt_event & $past(~flt_cond & flt_down)) != 16'h0);
    endproperty
    a_flt_fall_latch: assert property (p_flt_fall_latch)
        else $error("fault falling edge not latched");

    property p_flt_no_filter;
        (flt_event & ~$past(flt_event) & ~$past(flt_up | flt_down)
            & ~$past(flt_up | flt_down, 2)) == 16'h0;
    endproperty
    a_flt_no_filter: assert property (p_flt_no_filter)
        else $error("fault event set with both filters clear");

    property p_act_read_clear;
        is_read && sel_is(cmd_sel_i, `SEA_SEL_ACT_EVENT)
            && act_cond == $past(act_cond) && act_up == $past(act_up)
            && act_down == $past(act_down)
            |=> act_event == 16'h0 && rsp_valid_o
                && rsp_data_o == $past(act_event);
    endproperty
    a_act_read_clear: assert property (p_act_read_clear)
        else $error("activity event read did not return and clear");

    property p_flt_read_clear;
        is_read && sel_is(cmd_sel_i, `SEA_SEL_FLT_EVENT)
            && flt_cond == $past(flt_cond) && flt_up == $past(flt_up)
            && flt_down == $past(flt_down)
            |=> flt_event == 16'h0 && rsp_data_o == $past(flt_event);
    endproperty
    a_flt_read_clear: assert property (p_flt_read_clear)
        else $error("fault event read did not return and clear");

    property p_act_summary;
        status_summary_o[`SEA_SB_ACT_BIT] == |(act_event & act_enable);
    endproperty
    a_act_summary: assert property (p_act_summary)
        else $error("activity summary mismatch");

    property p_flt_summary;
        status_summary_o[`SEA_SB_FLT_BIT] == |(flt_event & flt_enable);
    endproperty
    a_flt_summary: assert property (p_flt_summary)
        else $error("fault summary mismatch");

    property p_preset;
        is_preset |=> act_up == `SEA_ACT_UP_PRESET
            && flt_up == `SEA_FLT_UP_PRESET && act_down == 16'h0
            && flt_down == 16'h0 && act_enable == 16'h0
            && flt_enable == 16'h0;
    endproperty
    a_preset: assert property (p_preset)
        else $error("defaults load wrong");

    property p_enable_readback;
        is_write && sel_is(cmd_sel_i, `SEA_SEL_ACT_ENABLE)
            ##1 is_read && sel_is(cmd_sel_i, `SEA_SEL_ACT_ENABLE)
            |=> rsp_data_o == ($past(cmd_wdata_i, 2) & `SEA_WRITE_MASK);
    endproperty
    a_enable_readback: assert property (p_enable_readback)
        else $error("activity enable readback wrong");

    property p_unused_zero;
        (act_event & ~`SEA_ACT_USED) == 16'h0
            && (flt_event & ~`SEA_FLT_USED) == 16'h0
            && (act_cond & ~`SEA_ACT_USED) == 16'h0;
    endproperty
    a_unused_zero: assert property (p_unused_zero)
        else $error("unused bit set");

    // a pin dropping in the cycle after the write legally cancels the event
    property p_filter_write_event;
        is_write && sel_is(cmd_sel_i, `SEA_SEL_ACT_UP)
            && ((act_cond & ~act_up & cmd_wdata_i) != 16'h0)
            && act_cond == $past(act_cond)
            |=> ((act_cond & $past(act_cond & ~act_up & cmd_wdata_i)) == 16'h0)
                or ##1 act_event != 16'h0;
    endproperty
    a_filter_write_event: assert property (p_filter_write_event)
        else $error("filter write did not raise event");

    property p_act_fall_latch;
        ((~act_cond & $past(act_cond) & act_down & $past(act_down)) != 16'h0)
            |=> ((act_event & $past(~act_cond & act_down)) != 16'h0);
    endproperty
    a_act_fall_latch: assert property (p_act_fall_latch)
        else $error("activity falling edge not latched");

    property p_flt_rise_latch;
        ((flt_cond & ~$past(flt_cond) & flt_up & $past(flt_up)) != 16'h0)
            |=> ((flt_event & $past(flt_cond & flt_up)) != 16'h0);
    endproperty
    a_flt_rise_latch: assert property (p_flt_rise_latch)
        else $error("fault rising edge not latched");

    property p_act_no_filter;
        (act_event & ~$past(act_event) & ~$past(act_up | act_down)) == 16'h0;
    endproperty
    a_act_no_filter: assert property (p_act_no_filter)
        else $error("activity event set with both filters clear");

    property p_rsp_pulse;
        rsp_valid_o == $past(is_read);
    endproperty
    a_rsp_pulse: assert property (p_rsp_pulse)
        else $error("read answer pulse wrong");

    c_act_event: cover property (act_event != 16'h0 ##1 activity_summary_o);
    c_flt_read: cover property (is_read
        && sel_is(cmd_sel_i, `SEA_SEL_FLT_EVENT) && flt_event != 16'h0);
    c_preset: cover property (is_preset ##1 fault_summary_o == 1'b0);
    c_filter_event: cover property (is_write
        && sel_is(cmd_sel_i, `SEA_SEL_ACT_UP) ##2 act_event != 16'h0);
    c_both_filters: cover property ((act_up & act_down & act_event) != 16'h0);
endmodule : sea_top

// *** sim/test_status_event_aggregator.sv ***
// self-checking bench for the status event aggregator
`timescale 1ns/100ps
`include "sea_regs.svh"
module test_status_event_aggregator import sea_pkg::*; ();

    localparam sea_word_t AU = `SEA_ACT_USED;
    localparam sea_word_t FU = `SEA_FLT_USED;
    localparam sea_word_t ALL = 16'h7fff;

    logic       clk;
    logic       rst_b;
    logic       calibrating;
    logic       awaiting_launch;
    logic       voltage_regulating;
    logic       current_regulating;
    logic       excess_voltage_fault;
    logic       excess_current_fault;
    logic       heat_fault;
    logic       remote_inhibit;
    logic       regulation_lost;
    logic       cmd_valid;
    logic [1:0] cmd_op;
    logic [3:0] cmd_sel;
    sea_word_t  cmd_wdata;
    logic       rsp_valid;
    sea_word_t  rsp_data;
    logic       act_sum;
    logic       flt_sum;
    logic [7:0] status_sum;
    int         err_total;
    int         n_checks;
    sea_word_t  w;
    logic [3:0] rw_sel [6];

    sea_top u_dut (
        .ref_clk_i              (clk),
        .rst_b_i                (rst_b),
        .calibrating_i          (calibrating),
        .awaiting_launch_i      (awaiting_launch),
        .voltage_regulating_i   (voltage_regulating),
        .current_regulating_i   (current_regulating),
        .excess_voltage_fault_i (excess_voltage_fault),
        .excess_current_fault_i (excess_current_fault),
        .heat_fault_i           (heat_fault),
        .remote_inhibit_i       (remote_inhibit),
        .regulation_lost_i      (regulation_lost),
        .cmd_valid_i            (cmd_valid),
        .cmd_op_i               (cmd_op),
        .cmd_sel_i              (cmd_sel),
        .cmd_wdata_i            (cmd_wdata),
        .rsp_valid_o            (rsp_valid),
        .rsp_data_o             (rsp_data),
        .activity_summary_o     (act_sum),
        .fault_summary_o        (flt_sum),
        .status_summary_o       (status_sum)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input sea_word_t seen, input sea_word_t exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle

    // one command pulse, taken at the next edge
    task automatic issue(input logic [1:0] op, input logic [3:0] sel,
                         input sea_word_t d);
        cmd_valid = 1'b1;
        cmd_op    = op;
        cmd_sel   = sel;
        cmd_wdata = d;
        settle(1);
        cmd_valid = 1'b0;
        cmd_op    = SEA_OP_NONE;
    endtask : issue

    // write then let the stored value and any filter event land
    task automatic wr(input logic [3:0] sel, input sea_word_t d);
        issue(SEA_OP_WRITE, sel, d);
        settle(3);
    endtask : wr

    task automatic rd_chk(input logic [3:0] sel, input sea_word_t exp);
        int n;
        n = 0;
        issue(SEA_OP_READ, sel, 16'h0000);
        while (rsp_valid !== 1'b1 && n < 4) begin
            settle(1);
            n++;
        end
        chk(rsp_data, exp);
        chk({15'h0000, rsp_valid}, 16'h0001);
        settle(1);
    endtask : rd_chk

    // drain both event registers without judging them
    task automatic clr();
        issue(SEA_OP_READ, `SEA_SEL_ACT_EVENT, 16'h0000);
        settle(1);
        issue(SEA_OP_READ, `SEA_SEL_FLT_EVENT, 16'h0000);
        settle(2);
    endtask : clr

    task automatic set_pins(input sea_word_t a, input sea_word_t f);
        calibrating          = a[`SEA_ACT_CAL_BIT];
        awaiting_launch      = a[`SEA_ACT_WAIT_BIT];
        voltage_regulating   = a[`SEA_ACT_VREG_BIT];
        current_regulating   = a[`SEA_ACT_IREG_BIT];
        excess_voltage_fault = f[`SEA_FLT_OV_BIT];
        excess_current_fault = f[`SEA_FLT_OC_BIT];
        heat_fault           = f[`SEA_FLT_HEAT_BIT];
        remote_inhibit       = f[`SEA_FLT_INH_BIT];
        regulation_lost      = f[`SEA_FLT_UNREG_BIT];
        settle(5);
    endtask : set_pins

    task automatic sum_chk(input sea_word_t exp);
        settle(3);
        chk({6'h00, act_sum, flt_sum, status_sum}, exp);
    endtask : sum_chk

    task automatic set_filters(input sea_word_t up, input sea_word_t dn);
        wr(`SEA_SEL_ACT_UP, up);
        wr(`SEA_SEL_FLT_UP, up);
        wr(`SEA_SEL_ACT_DOWN, dn);
        wr(`SEA_SEL_FLT_DOWN, dn);
    endtask : set_filters

    task automatic ev_chk(input sea_word_t a, input sea_word_t f);
        rd_chk(`SEA_SEL_ACT_EVENT, a);
        rd_chk(`SEA_SEL_FLT_EVENT, f);
    endtask : ev_chk

    initial begin
        repeat (8000) @(posedge clk);
        err_total++;
        end_of_test();
    end

    initial begin
        err_total = 0;
        n_checks  = 0;
        rst_b     = 1'b0;
        cmd_valid = 1'b0;
        cmd_op    = SEA_OP_NONE;
        cmd_sel   = 4'h0;
        cmd_wdata = 16'h0000;
        rw_sel    = '{`SEA_SEL_ACT_ENABLE, `SEA_SEL_ACT_DOWN, `SEA_SEL_ACT_UP,
                      `SEA_SEL_FLT_ENABLE, `SEA_SEL_FLT_DOWN, `SEA_SEL_FLT_UP};
        set_pins(16'h0000, 16'h0000);
        settle(1);
        rst_b = 1'b1;
        sum_chk(16'h0000);
        // storage: distinct values so aliasing between registers shows
        for (int i = 0; i < 6; i++) begin
            rd_chk(rw_sel[i], 16'h0000);
            wr(rw_sel[i], ALL - sea_word_t'(i));
        end
        for (int i = 0; i < 6; i++) begin
            rd_chk(rw_sel[i], ALL - sea_word_t'(i));
        end
        wr(`SEA_SEL_ACT_ENABLE, 16'h2a55);
        rd_chk(`SEA_SEL_ACT_ENABLE, 16'h2a55);
        wr(`SEA_SEL_ACT_COND, ALL);
        rd_chk(`SEA_SEL_ACT_COND, 16'h0000);
        rd_chk(4'h5, 16'h0000);
        // defaults load over nonzero contents
        issue(SEA_OP_PRESET, 4'h0, 16'h0000);
        settle(2);
        rd_chk(`SEA_SEL_ACT_UP, 16'h0521);
        rd_chk(`SEA_SEL_FLT_UP, 16'h0613);
        for (int i = 0; i < 6; i++) begin
            if (i != 2 && i != 5) begin
                rd_chk(rw_sel[i], 16'h0000);
            end
        end
        // one bit position at a time on both groups: each pin lands on its own bit, spare bits stay zero
        set_filters(16'h0000, 16'h0000);
        for (int i = 0; i < 16; i++) begin
            w = sea_word_t'(1) << i;
            set_pins(w, w);
            rd_chk(`SEA_SEL_ACT_COND, w & AU);
            rd_chk(`SEA_SEL_FLT_COND, w & FU);
        end
        set_pins(16'h0000, 16'h0000);
        clr();
        ev_chk(16'h0000, 16'h0000);
        // rising edges only
        set_filters(ALL, 16'h0000);
        clr();
        set_pins(AU, FU);
        rd_chk(`SEA_SEL_ACT_COND, AU);
        ev_chk(AU, FU);
        ev_chk(16'h0000, 16'h0000);
        // falling edges only
        set_filters(16'h0000, ALL);
        clr();
        set_pins(16'h0000, 16'h0000);
        ev_chk(AU, FU);
        ev_chk(16'h0000, 16'h0000);
        // no filter bits: both directions blocked
        set_filters(16'h0000, 16'h0000);
        set_pins(AU, FU);
        set_pins(16'h0000, 16'h0000);
        ev_chk(16'h0000, 16'h0000);
        // both filter bits: each direction latches
        set_filters(ALL, ALL);
        clr();
        set_pins(AU, FU);
        ev_chk(AU, FU);
        set_pins(16'h0000, 16'h0000);
        ev_chk(AU, FU);
        // filter writes alone raising events
        set_filters(16'h0000, 16'h0000);
        set_pins(AU, FU);
        clr();
        wr(`SEA_SEL_ACT_UP, 16'h0400);
        wr(`SEA_SEL_FLT_UP, 16'h0200);
        ev_chk(16'h0400, 16'h0200);
        set_pins(16'h0000, 16'h0000);
        ev_chk(16'h0000, 16'h0000);
        wr(`SEA_SEL_ACT_DOWN, 16'h0001);
        rd_chk(`SEA_SEL_ACT_EVENT, 16'h0001);
        // summaries: latched events masked, then enabled one group at a time
        set_filters(ALL, 16'h0000);
        wr(`SEA_SEL_ACT_ENABLE, ALL & ~AU);
        wr(`SEA_SEL_FLT_ENABLE, ALL & ~FU);
        clr();
        set_pins(AU, FU);
        sum_chk(16'h0000);
        wr(`SEA_SEL_ACT_ENABLE, 16'h0020);
        sum_chk(16'h0280);
        wr(`SEA_SEL_FLT_ENABLE, 16'h0010);
        sum_chk(16'h0388);
        rd_chk(`SEA_SEL_ACT_EVENT, AU);
        sum_chk(16'h0108);
        rd_chk(`SEA_SEL_FLT_EVENT, FU);
        sum_chk(16'h0000);
        end_of_test();
    end

endmodule : test_status_event_aggregator
